// >>> rtl/csie_consts.svh
/*
 * constants of the clock-source interrupt enable block: register offsets,
 * source bit positions, field positions and reset values.
 * assumes it is included by bare name, once or more, ahead of any user.
 */
`ifndef CSIE_CONSTS_SVH
`define CSIE_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the peripheral bus
// ----------------------------------------------------------------------
`define CSIE_ADDR_W                  12
`define CSIE_OFF_EN_CLR              12'h000
`define CSIE_OFF_EN_SET              12'h004
`define CSIE_OFF_FLAG                12'h008
`define CSIE_OFF_STATUS              12'h00c
`define CSIE_OFF_WPROT               12'h010

// ----------------------------------------------------------------------
// source bit positions, shared by enable, flag and status layouts
// ----------------------------------------------------------------------
`define CSIE_NUM_SRC                 12
`define CSIE_BIT_BROWNOUT_SYNC_READY 11
`define CSIE_BIT_BROWNOUT_DETECTION  10
`define CSIE_BIT_BROWNOUT_READY      9
`define CSIE_BIT_LOOP_REFCLK_STOPPED 8
`define CSIE_BIT_LOOP_COARSE_LOCK    7
`define CSIE_BIT_LOOP_FINE_LOCK      6
`define CSIE_BIT_LOOP_OUT_OF_BOUNDS  5
`define CSIE_BIT_LOOP_READY          4
`define CSIE_BIT_FAST_RC_READY       3
`define CSIE_BIT_SLOW_RC_READY       2
`define CSIE_BIT_SLOW_CRYSTAL_READY  1
`define CSIE_BIT_MAIN_CRYSTAL_READY  0

// ----------------------------------------------------------------------
// write-protect register field
// ----------------------------------------------------------------------
`define CSIE_BIT_WPROT_ON            0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CSIE_EN_RESET                12'h000
`define CSIE_FLAG_RESET              12'h000
`define CSIE_WPROT_RESET             1'b0
`define CSIE_SYNC_RESET              1'b0
`define CSIE_RDATA_RESET             32'h0000_0000

`endif

// >>> rtl/csie_pkg.sv
/*
 * types of the clock-source interrupt enable block.
 * assumes csie_consts.svh is on the include path.
 */
`include "csie_consts.svh"

package csie_pkg;

    // ------------------------------------------------------------------
    // one bit per interrupt source, bit 11 first
    // ------------------------------------------------------------------
    typedef struct packed {
        logic brownout_sync_ready;   // bit 11
        logic brownout_detection;    // bit 10
        logic brownout_ready;        // bit 9
        logic loop_refclk_stopped;   // bit 8
        logic loop_coarse_lock;      // bit 7
        logic loop_fine_lock;        // bit 6
        logic loop_out_of_bounds;    // bit 5
        logic loop_ready;            // bit 4
        logic fast_rc_ready;         // bit 3
        logic slow_rc_ready;         // bit 2
        logic slow_crystal_ready;    // bit 1
        logic main_crystal_ready;    // bit 0
    } csie_src_t;

    // ------------------------------------------------------------------
    // one-hot register select, latched in the apb setup cycle
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        CSIE_SEL_NONE   = 6'b000001,
        CSIE_SEL_EN_CLR = 6'b000010,
        CSIE_SEL_EN_SET = 6'b000100,
        CSIE_SEL_FLAG   = 6'b001000,
        CSIE_SEL_STATUS = 6'b010000,
        CSIE_SEL_WPROT  = 6'b100000
    } csie_sel_t;

endpackage : csie_pkg

// >>> rtl/csie_sync.sv
/*
 * two-flop synchroniser bank for the oscillator and brown-out status lines.
 * assumes each input bit changes slowly against clk; bits are independent.
 */
`timescale 1ns/1ps
`default_nettype none

module csie_sync #(
    parameter int W = 12                  // number of lines
) (
    input  wire logic         clk,        // bus clock
    input  wire logic         resetn,     // async reset, active low
    input  wire logic         ce,         // clock enable, freezes state
    input  wire logic [W-1:0] d_in,       // asynchronous lines
    output var  logic [W-1:0] q_out       // synchronised lines
);

    // ------------------------------------------------------------------
    // one pair of flops per line; the first is read by the second only
    // ------------------------------------------------------------------
    logic [W-1:0] meta_q;                 // first stage

    for (genvar i = 0; i < W; i++)
    begin : g_bit
        // two-stage capture of one line
        always_ff @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                meta_q[i] <= `CSIE_SYNC_RESET;
                q_out[i]  <= `CSIE_SYNC_RESET;
            end
            else if (ce)
            begin
                meta_q[i] <= d_in[i];
                q_out[i]  <= meta_q[i];
            end
        end
    end

endmodule : csie_sync

`default_nettype wire

// >>> rtl/csie_top.sv
/*
 * clock-source interrupt enable block: apb slave holding a shared enable
 * vector reached through write-one-to-set and write-one-to-clear views,
 * sticky interrupt flags raised on rising status lines, a write-protect
 * switch and one level interrupt output.
 * assumes an apb master on clk and status lines from other clock domains.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module csie_top
    import csie_pkg::*;
(
    input  wire logic                    clk,           // bus clock, 200 mhz
    input  wire logic                    resetn,        // async reset, active low
    input  wire logic                    ce,            // clock enable
    input  wire logic                    psel,          // apb select
    input  wire logic                    penable,       // apb access phase
    input  wire logic                    pwrite,        // apb direction
    input  wire logic [`CSIE_ADDR_W-1:0] paddr,         // apb byte address
    input  wire logic [31:0]             pwdata,        // apb write data
    input  wire logic [3:0]              pstrb,         // apb byte strobes
    output var  logic [31:0]             prdata,        // apb read data
    output var  logic                    pready,        // apb ready
    output var  logic                    pslverr,       // apb error
    input  wire csie_src_t               status_in,     // raw status lines
    output var  csie_src_t               src_req,       // per-source request
    output var  logic                    irq            // level interrupt
);

    // ------------------------------------------------------------------
    // local widths
    // ------------------------------------------------------------------
    localparam int N = `CSIE_NUM_SRC;                   // source count

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [N-1:0] en_q;                                 // shared enables
    logic [N-1:0] en_d;                                 // next enables
    logic [N-1:0] flag_q;                               // sticky flags
    logic [N-1:0] flag_d;                               // next flags
    logic [N-1:0] stat_sync;                            // synced status
    logic [N-1:0] stat_prev_q;                          // status last cycle
    logic [N-1:0] stat_rise;                            // rising edges
    logic         wprot_q;                              // protection on
    logic         wprot_d;                              // next protection
    csie_sel_t    sel_q;                                // latched select
    csie_sel_t    sel_dec;                              // decoded address
    logic         err_q;                                // latched error
    logic         err_dec;                              // error of request
    logic [N-1:0] wmask;                                // lanes as bit mask
    logic [N-1:0] wbits;                                // written ones
    logic         setup;                                // setup phase seen
    logic         access;                               // access completes
    logic         wr_ok;                                // write that acts
    logic [31:0]  rdata_dec;                            // read mux value
    logic [N-1:0] req_d;                                // next requests

    // ------------------------------------------------------------------
    // status synchroniser
    // ------------------------------------------------------------------
    csie_sync #(
        .W      (N)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .d_in   (status_in),
        .q_out  (stat_sync)
    );

    // ------------------------------------------------------------------
    // status edge detection
    // ------------------------------------------------------------------
    // previous synced status, for zero-to-one detection
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stat_prev_q <= `CSIE_FLAG_RESET;
        end
        else if (ce)
        begin
            stat_prev_q <= stat_sync;
        end
    end

    // a flag source is a rise of its synced status line
    assign stat_rise = stat_sync & ~stat_prev_q;

    // ------------------------------------------------------------------
    // apb phase decode
    // ------------------------------------------------------------------
    // setup cycle: select without enable
    assign setup  = ce & psel & ~penable;
    // access completes at the edge where ready is seen high
    assign access = ce & psel & penable & pready;
    // only an access without error changes state
    assign wr_ok  = access & pwrite & ~err_q;

    // byte strobes widened to the twelve implemented bits
    assign wmask  = {{4{pstrb[1]}}, {8{pstrb[0]}}};
    // only written ones act; written zeros change nothing
    assign wbits  = pwdata[N-1:0] & wmask;

    // ------------------------------------------------------------------
    // address decode and error check
    // ------------------------------------------------------------------
    // map the byte address onto a one-hot select
    always_comb
    begin
        sel_dec = CSIE_SEL_NONE;
        case (paddr)
            `CSIE_OFF_EN_CLR: sel_dec = CSIE_SEL_EN_CLR;  // clear view
            `CSIE_OFF_EN_SET: sel_dec = CSIE_SEL_EN_SET;  // set view
            `CSIE_OFF_FLAG:   sel_dec = CSIE_SEL_FLAG;    // flags
            `CSIE_OFF_STATUS: sel_dec = CSIE_SEL_STATUS;  // status
            `CSIE_OFF_WPROT:  sel_dec = CSIE_SEL_WPROT;   // protection
            default:          sel_dec = CSIE_SEL_NONE;    // unmapped
        endcase
    end

    // unmapped address, or enable write while protected, is an error
    always_comb
    begin
        err_dec = 1'b0;
        case (sel_dec)
            CSIE_SEL_NONE:
            begin
                err_dec = 1'b1;                         // nothing here
            end
            CSIE_SEL_EN_CLR,
            CSIE_SEL_EN_SET:
            begin
                err_dec = pwrite & wprot_q;
            end
            default:
            begin
                err_dec = 1'b0;                         // always allowed
            end
        endcase
    end

    // ------------------------------------------------------------------
    // read data multiplexer
    // ------------------------------------------------------------------
    // both enable views read the same vector, upper bits zero
    always_comb
    begin
        rdata_dec = `CSIE_RDATA_RESET;
        case (sel_dec)
            CSIE_SEL_EN_CLR,
            CSIE_SEL_EN_SET:
            begin
                rdata_dec[N-1:0] = en_q;
            end
            CSIE_SEL_FLAG:
            begin
                rdata_dec[N-1:0] = flag_q;              // sticky flags
            end
            CSIE_SEL_STATUS:
            begin
                rdata_dec[N-1:0] = stat_sync;           // live status
            end
            CSIE_SEL_WPROT:
            begin
                rdata_dec[`CSIE_BIT_WPROT_ON] = wprot_q;  // switch state
            end
            default:
            begin
                rdata_dec = `CSIE_RDATA_RESET;          // unmapped reads 0
            end
        endcase
    end

    // ------------------------------------------------------------------
    // apb response registers
    // ------------------------------------------------------------------
    // ready rises for exactly the one access cycle after setup
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
        end
        else if (ce)
        begin
            pready <= setup;
        end
    end

    // select, error and read data are captured in the setup cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_q   <= CSIE_SEL_NONE;
            err_q   <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `CSIE_RDATA_RESET;
        end
        else if (setup)
        begin
            sel_q   <= sel_dec;
            err_q   <= err_dec;
            pslverr <= err_dec;
            prdata  <= pwrite ? `CSIE_RDATA_RESET : rdata_dec;
        end
        else if (access)
        begin
            // drop the answer once the access has completed
            pslverr <= 1'b0;
            prdata  <= `CSIE_RDATA_RESET;
        end
    end

    // ------------------------------------------------------------------
    // enable vector
    // ------------------------------------------------------------------
    // bit layout follows the source struct, msb first
    // bits 11..8 brownout sync, detection, ready, refclk stopped
    // bits 7..4 coarse lock, fine lock, out of bounds, ready
    // bits 3..0 fast rc, slow rc, slow crystal, main crystal
    always_comb
    begin
        en_d = en_q;
        if (wr_ok)
        begin
            case (sel_q)
                CSIE_SEL_EN_SET:
                begin
                    en_d = en_q | wbits;
                end
                CSIE_SEL_EN_CLR:
                begin
                    en_d = en_q & ~wbits;
                end
                default:
                begin
                    en_d = en_q;                        // other registers
                end
            endcase
        end
    end

    // enable storage, all clear after reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_q <= `CSIE_EN_RESET;
        end
        else if (ce)
        begin
            en_q <= en_d;
        end
    end

    // ------------------------------------------------------------------
    // sticky interrupt flags
    // ------------------------------------------------------------------
    // write one clears; a rise in the same cycle wins over the clear
    always_comb
    begin
        flag_d = flag_q;
        if (wr_ok && (sel_q == CSIE_SEL_FLAG))
        begin
            flag_d = flag_q & ~wbits;
        end
        flag_d = flag_d | stat_rise;
    end

    // flag storage
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flag_q <= `CSIE_FLAG_RESET;
        end
        else if (ce)
        begin
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------------
    // write-protect switch
    // ------------------------------------------------------------------
    // the switch itself is never protected, so it can always be undone
    always_comb
    begin
        wprot_d = wprot_q;
        if (wr_ok && (sel_q == CSIE_SEL_WPROT) && pstrb[0])
        begin
            wprot_d = pwdata[`CSIE_BIT_WPROT_ON];
        end
    end

    // protection storage, off after reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wprot_q <= `CSIE_WPROT_RESET;
        end
        else if (ce)
        begin
            wprot_q <= wprot_d;
        end
    end

    // ------------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------------
    // a source requests only while both its flag and enable are set
    assign req_d = flag_d & en_d;

    // registered per-source requests and their combined level
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            src_req <= csie_src_t'(`CSIE_EN_RESET);
            irq     <= 1'b0;
        end
        else if (ce)
        begin
            src_req <= csie_src_t'(req_d);
            irq     <= |req_d;
        end
    end

endmodule : csie_top

`default_nettype wire

// >>> verification/csie_props.sv
/*
 * port checker of the clock-source interrupt enable block.
 * assumes it is bound onto csie_top, one clock domain, ce held high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "csie_consts.svh"

module csie_props
    import csie_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire logic                    ce,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`CSIE_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire csie_src_t               status_in,
    input wire csie_src_t               src_req,
    input wire logic                    irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic        acc;        // completing apb transfer
    logic        en_view;    // transfer hits an enable view
    logic        prot_q;     // mirror of the protect bit
    logic [2:0]  quiet_q;    // edges the status lines have held
    logic [11:0] stat_q;     // status seen last edge
    logic [11:0] set_q;      // bits just written to the set view
    assign acc     = psel & penable & pready & ce;
    assign en_view = (paddr == `CSIE_OFF_EN_CLR) || (paddr == `CSIE_OFF_EN_SET);

    // protect bit follows completed writes to its register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn) prot_q <= 1'b0;
        else if (acc && pwrite && paddr == `CSIE_OFF_WPROT) prot_q <= pwdata[0];
    end

    // quiet count: a status rise needs three edges to reach a request
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn) quiet_q <= 3'h0;
        else if (status_in != stat_q) quiet_q <= 3'h0;
        else if (quiet_q != 3'h6) quiet_q <= quiet_q + 3'h1;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn) stat_q <= 12'h000;
        else stat_q <= status_in;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn) set_q <= 12'h000;
        else set_q <= (acc && pwrite && paddr == `CSIE_OFF_EN_SET) ? pwdata[11:0] : 12'h000;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_NO_RISE: assert property (
        quiet_q > 3'h4 |=> (src_req & ~$past(src_req) & ~set_q) == 12'h000)
        else $error("request rose without set write or status rise");
    AST_CLR_DROP: assert property (
        acc && pwrite && !pslverr && paddr == `CSIE_OFF_EN_CLR
        |=> (src_req & $past(pwdata[11:0])) == 12'h000)
        else $error("cleared enable still requests");
    AST_IRQ_OR: assert property (
        irq == (src_req != 12'h000))
        else $error("irq differs from or of requests");
    AST_RST_QUIET: assert property (
        $rose(resetn) |-> src_req == 12'h000 && !irq)
        else $error("request present after reset");
    AST_PROT_ERR: assert property (
        acc && pwrite && en_view |-> pslverr == prot_q)
        else $error("protected enable write answered wrongly");
    AST_UPPER_ZERO: assert property (
        acc && !pwrite && en_view |-> prdata[31:12] == 20'h00000 && !pslverr)
        else $error("enable view upper bits not zero");
    AST_UNMAPPED: assert property (
        acc && paddr > `CSIE_OFF_WPROT |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_SETUP_RDY: assert property (
        psel && !penable && ce |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    AST_RDY_CAUSE: assert property (
        pready |-> $past(psel && !penable))
        else $error("ready without setup");

    // ------------------------------------------------------------------
    // covers
    // ------------------------------------------------------------------
    COV_IRQ: cover property ($rose(irq));
    COV_PROT: cover property (acc && pwrite && pslverr && en_view);
    COV_CLR: cover property (acc && pwrite && paddr == `CSIE_OFF_EN_CLR);
endmodule : csie_props

bind csie_top csie_props i_props (
    .clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_in(status_in), .src_req(src_req), .irq(irq)
);
`default_nettype wire

// >>> verification/testbench.sv
/*
 * self-checking bench of csie_top: apb master with expectation queue,
 * status stimulus and request checks.
 * assumes the design files are compiled first; ce and strobes held.
 */
`timescale 1ns/1ps
`default_nettype none
`include "csie_consts.svh"

module testbench
    import csie_pkg::*;
;
    localparam logic [11:0] A_CLR = `CSIE_OFF_EN_CLR;
    localparam logic [11:0] A_SET = `CSIE_OFF_EN_SET;
    localparam logic [11:0] A_FLG = `CSIE_OFF_FLAG;
    localparam logic [11:0] A_PRT = `CSIE_OFF_WPROT;

    logic        clk = 1'b0;       // 200 mhz bus clock
    logic        resetn = 1'b0;    // active low reset
    logic        psel = 1'b0;      // apb select
    logic        penable = 1'b0;   // apb access
    logic        pwrite = 1'b0;    // apb direction
    logic [11:0] paddr = 12'h000;  // apb address
    logic [31:0] pwdata = 32'h0;   // apb write data
    logic [31:0] prdata;           // apb read data
    logic        pready;           // apb ready
    logic        pslverr;          // apb error
    logic        irq;              // level interrupt
    csie_src_t   status_in = 12'h000;  // raw status lines
    csie_src_t   src_req;              // per-source request
    logic [32:0] exp_q[$];         // expected error and data per transfer
    logic [11:0] en;               // expected enables
    logic [11:0] fl;               // expected flags
    logic [31:0] d;                // random word
    int          err_total = 0;
    int          comparisons = 0;
    int          cyc = 0;

    always #2.5 clk = ~clk;
    csie_top i_dut (
        .clk(clk), .resetn(resetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .status_in(status_in), .src_req(src_req), .irq(irq)
    );

    // ------------------------------------------------------------------
    // reporting and comparison
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic fail(input string m);
        err_total++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail

    task automatic chk_bus(input logic [32:0] got, input logic [32:0] x);
        comparisons++;
        if (got !== x) fail($sformatf("bus got %h want %h", got, x));
    endtask : chk_bus

    task automatic chk_req(input logic [11:0] x);
        comparisons++;
        if (src_req !== x || irq !== (x != 12'h000)) fail($sformatf("req want %h", x));
    endtask : chk_req

    // ------------------------------------------------------------------
    // apb master: setup, access until ready, one idle cycle
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [32:0] x);
        exp_q.push_back(x);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic e);
        apb(1'b1, a, wd, {e, 32'h0});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, 32'h0, {e, x});
    endtask : rd

    // monitor: each completed transfer takes the oldest note
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            if (exp_q.size() == 0) fail("transfer without note");
            else chk_bus({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail("timeout");
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hd90bf98f));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(A_SET, 32'h0, 1'b0);
        rd(A_CLR, 32'h0, 1'b0);
        status_in <= 12'hfff;
        repeat (6) @(posedge clk);
        chk_req(12'h000);
        fl = 12'hfff;
        rd(A_FLG, {20'h0, fl}, 1'b0);
        $display("test reset and masked flags done");
        en = 12'h000;
        for (int i = 0; i < 12; i++)
        begin
            wr(A_SET, 32'hffff_f000 | (32'h1 << i), 1'b0);
            en[i] = 1'b1;
            chk_req(en);
            rd(A_SET, {20'h0, en}, 1'b0);
        end
        wr(A_SET, 32'h0, 1'b0);
        wr(A_CLR, 32'h0, 1'b0);
        rd(A_CLR, {20'h0, en}, 1'b0);
        wr(A_CLR, 32'h4, 1'b0);
        en[2] = 1'b0;
        chk_req(en);
        rd(A_SET, {20'h0, en}, 1'b0);
        $display("test set and clear views done");
        d = $urandom;
        wr(A_FLG, d, 1'b0);
        fl = fl & ~d[11:0];
        chk_req(en & fl);
        status_in <= 12'h000;
        repeat (3) @(posedge clk);
        d = $urandom;
        status_in <= d[11:0];
        repeat (6) @(posedge clk);
        fl = fl | d[11:0];
        rd(A_FLG, {20'h0, fl}, 1'b0);
        chk_req(en & fl);
        rd(`CSIE_OFF_STATUS, {20'h0, d[11:0]}, 1'b0);
        $display("test flags done");
        wr(A_PRT, 32'h1, 1'b0);
        wr(A_SET, 32'hfff, 1'b1);
        wr(A_CLR, 32'hfff, 1'b1);
        rd(A_SET, {20'h0, en}, 1'b0);
        wr(A_PRT, 32'h0, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        $display("test protection and unmapped done");
        for (int k = 0; k < 16; k++)
        begin
            d = $urandom;
            if (d[31])
            begin
                wr(A_SET, d, 1'b0);
                en = en | d[11:0];
            end
            else
            begin
                wr(A_CLR, d, 1'b0);
                en = en & ~d[11:0];
            end
            chk_req(en & fl);
            rd(d[30] ? A_SET : A_CLR, {20'h0, en}, 1'b0);
        end
        $display("test random enables done");
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(A_SET, 32'h0, 1'b0);
        chk_req(12'h000);
        $display("test second reset done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
